/* rtl/smaf_pkg.sv */
package smaf_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXDATA = 8'h04;
    localparam logic [7:0] REG_RXDATA = 8'h08;
    localparam logic [7:0] REG_BAUD = 8'h0c;
    localparam logic [7:0] REG_ADDR = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    // control register fields
    localparam int CTRL_MODE_HIGH = 7;
    localparam int CTRL_MODE_LOW = 6;
    localparam int CTRL_FILTER = 5;
    localparam int CTRL_RX_ENABLE = 4;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_FAST = 1;
    // status and mask fields
    localparam int STAT_RX_DONE = 0;
    localparam int STAT_TX_DONE = 1;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h006c;
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam logic [1:0] IRQ_RST = 2'h0;
    // modes as {mode_select_high, mode_select_low}
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_FIXED9 = 2'h2;
    localparam logic [1:0] MODE_VAR9 = 2'h3;
    // bit times in oscillator cycles
    localparam logic [15:0] MODE0_DIV = 16'h000c;
    localparam logic [15:0] MODE0_HALF = 16'h0006;
    localparam logic [15:0] FIXED_SLOW = 16'h0040;
    localparam logic [15:0] FIXED_FAST = 16'h0020;
    // frame lengths in bits after the start bit, or after the first data bit in mode 00
    localparam logic [3:0] LEN_SHIFT = 4'h7;
    localparam logic [3:0] LEN_UART8 = 4'h9;
    localparam logic [3:0] LEN_UART9 = 4'ha;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/smaf_top.sv */
`timescale 1ns/1ps
module smaf_top
    import smaf_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial line
    input wire logic rxd,
    output logic txd,
    output logic shift_data_out,
    output logic shift_data_oe,
    // interrupt
    output logic irq
);
    import smaf_pkg::*;

    typedef enum {TX_IDLE, TX_RUN} smaf_tx_type;
    typedef enum {RX_IDLE, RX_RUN} smaf_rx_type;

    function automatic logic [15:0] bit_cycles(input logic [1:0] m, input logic fast, input logic [15:0] div);
        if (m == MODE_SHIFT)
            return MODE0_DIV;
        else if (m == MODE_FIXED9)
            return fast ? FIXED_FAST : FIXED_SLOW;
        else
            return (div == 16'h0000) ? 16'h0001 : div;
    endfunction

    // given = value & mask, broadcast = value | mask; zero mask bits never matter to given, zero broadcast bits never matter to broadcast
    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] val, input logic [7:0] msk);
        logic [7:0] bcast;
        bcast = val | msk;
        return ((b & msk) == (val & msk)) || ((b | ~bcast) == 8'hff);
    endfunction

    logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0] ctrl_q, ctrl_d, txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
    logic [15:0] baud_q, baud_d, addr_q, addr_d;
    logic [1:0] status_q, status_d, mask_q, mask_d;
    logic irq_q, irq_d, tx_start, do_wr;
    logic [1:0] mode;
    logic [15:0] period;
    assign mode = {ctrl_q[CTRL_MODE_HIGH], ctrl_q[CTRL_MODE_LOW]};
    assign period = bit_cycles(mode, ctrl_q[CTRL_FAST], baud_q);

    smaf_tx_type tx_st_q, tx_st_d;
    logic [15:0] tx_tmr_q, tx_tmr_d;
    logic [9:0] tx_sh_q, tx_sh_d;
    logic [3:0] tx_cnt_q, tx_cnt_d;
    logic txd_q, txd_d, sdo_q, sdo_d, soe_q, soe_d, tx_done;
    smaf_rx_type rx_st_q, rx_st_d;
    logic [15:0] rx_tmr_q, rx_tmr_d;
    logic [9:0] rx_sh_q, rx_sh_d, rx_nxt;
    logic [3:0] rx_cnt_q, rx_cnt_d;
    logic rx_fire, rx_done, rx_stop, rx_hit, rx_ninth;
    logic [7:0] rx_byte;

    // bus slave and register file
    always_comb
    begin
        aw_have_d = aw_have_q;
        awaddr_d = awaddr_q;
        w_have_d = w_have_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        txbuf_d = txbuf_q;
        rxbuf_d = rxbuf_q;
        baud_d = baud_q;
        addr_d = addr_q;
        mask_d = mask_q;
        status_d = status_q;
        tx_start = 1'b0;
        do_wr = aw_have_q && w_have_q && !bvalid_q;
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            if (awaddr_q == REG_CTRL)
            begin
                if (wstrb_q[0])
                    ctrl_d = wdata_q[7:0];
            end
            else if (awaddr_q == REG_TXDATA)
            begin
                // a write while the transmitter is busy is dropped
                if (wstrb_q[0] && tx_st_q == TX_IDLE)
                begin
                    txbuf_d = wdata_q[7:0];
                    tx_start = 1'b1;
                end
            end
            else if (awaddr_q == REG_RXDATA)
                bresp_d = RESP_OKAY;
            else if (awaddr_q == REG_BAUD)
            begin
                if (wstrb_q[0])
                    baud_d[7:0] = wdata_q[7:0];
                if (wstrb_q[1])
                    baud_d[15:8] = wdata_q[15:8];
            end
            else if (awaddr_q == REG_ADDR)
            begin
                if (wstrb_q[0])
                    addr_d[7:0] = wdata_q[7:0];
                if (wstrb_q[1])
                    addr_d[15:8] = wdata_q[15:8];
            end
            else if (awaddr_q == REG_STATUS)
            begin
                if (wstrb_q[0])
                    status_d = status_q & ~wdata_q[1:0];
            end
            else if (awaddr_q == REG_MASK)
            begin
                if (wstrb_q[0])
                    mask_d = wdata_q[1:0];
            end
            else
                bresp_d = RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            rdata_d = 32'h0000_0000;
            if (s_axi_araddr == REG_CTRL)
                rdata_d[7:0] = ctrl_q;
            else if (s_axi_araddr == REG_TXDATA)
                rdata_d[8:0] = {tx_st_q == TX_RUN, txbuf_q};
            else if (s_axi_araddr == REG_RXDATA)
                rdata_d[7:0] = rxbuf_q;
            else if (s_axi_araddr == REG_BAUD)
                rdata_d[15:0] = baud_q;
            else if (s_axi_araddr == REG_ADDR)
                rdata_d[15:0] = addr_q;
            else if (s_axi_araddr == REG_STATUS)
                rdata_d[1:0] = status_q;
            else if (s_axi_araddr == REG_MASK)
                rdata_d[1:0] = mask_q;
            else
                rresp_d = RESP_SLVERR;
        end
        // hardware events win over a clear in the same cycle
        if (rx_fire)
        begin
            status_d[STAT_RX_DONE] = 1'b1;
            rxbuf_d = rx_byte;
            if (mode != MODE_SHIFT)
                ctrl_d[CTRL_RX_NINTH] = rx_ninth;
        end
        if (tx_done)
            status_d[STAT_TX_DONE] = 1'b1;
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            aw_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            w_have_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            ctrl_q <= CTRL_RST;
            txbuf_q <= 8'h00;
            rxbuf_q <= 8'h00;
            baud_q <= BAUD_RST;
            addr_q <= ADDR_RST;
            status_q <= IRQ_RST;
            mask_q <= IRQ_RST;
            irq_q <= 1'b0;
        end
        else
        begin
            aw_have_q <= aw_have_d;
            awaddr_q <= awaddr_d;
            w_have_q <= w_have_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            ctrl_q <= ctrl_d;
            txbuf_q <= txbuf_d;
            rxbuf_q <= rxbuf_d;
            baud_q <= baud_d;
            addr_q <= addr_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    // transmitter; in mode 00 txd carries the shift clock for both directions
    always_comb
    begin
        tx_st_d = tx_st_q;
        tx_tmr_d = tx_tmr_q;
        tx_sh_d = tx_sh_q;
        tx_cnt_d = tx_cnt_q;
        txd_d = 1'b1;
        sdo_d = sdo_q;
        soe_d = soe_q;
        tx_done = 1'b0;
        if (tx_st_q == TX_IDLE)
        begin
            soe_d = 1'b0;
            if (tx_start)
            begin
                tx_st_d = TX_RUN;
                tx_tmr_d = period - 16'h0001;
                if (mode == MODE_SHIFT)
                begin
                    sdo_d = txbuf_d[0];
                    soe_d = 1'b1;
                    tx_sh_d = {3'b111, txbuf_d[7:1]};
                    tx_cnt_d = LEN_SHIFT;
                end
                else
                begin
                    txd_d = 1'b0;
                    // ninth slot is the stop bit in mode 01
                    tx_sh_d = {1'b1, (mode == MODE_UART8) | ctrl_q[CTRL_TX_NINTH], txbuf_d};
                    tx_cnt_d = (mode == MODE_UART8) ? LEN_UART8 : LEN_UART9;
                end
            end
        end
        else
        begin
            txd_d = txd_q;
            if (tx_tmr_q != 16'h0000)
                tx_tmr_d = tx_tmr_q - 16'h0001;
            else if (tx_cnt_q == 4'h0)
            begin
                tx_st_d = TX_IDLE;
                tx_done = 1'b1;
                txd_d = 1'b1;
                soe_d = 1'b0;
            end
            else
            begin
                tx_tmr_d = period - 16'h0001;
                tx_cnt_d = tx_cnt_q - 4'h1;
                tx_sh_d = {1'b1, tx_sh_q[9:1]};
                if (mode == MODE_SHIFT)
                    sdo_d = tx_sh_q[0];
                else
                    txd_d = tx_sh_q[0];
            end
        end
        // shift clock low for the first half of each bit, rising mid bit
        if (mode == MODE_SHIFT && tx_st_d == TX_RUN)
            txd_d = tx_tmr_d < MODE0_HALF;
        else if (mode == MODE_SHIFT && rx_st_d == RX_RUN)
            txd_d = rx_tmr_d < MODE0_HALF;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_st_q <= TX_IDLE;
            tx_tmr_q <= 16'h0000;
            tx_sh_q <= 10'h3ff;
            tx_cnt_q <= 4'h0;
            txd_q <= 1'b1;
            sdo_q <= 1'b1;
            soe_q <= 1'b0;
        end
        else
        begin
            tx_st_q <= tx_st_d;
            tx_tmr_q <= tx_tmr_d;
            tx_sh_q <= tx_sh_d;
            tx_cnt_q <= tx_cnt_d;
            txd_q <= txd_d;
            sdo_q <= sdo_d;
            soe_q <= soe_d;
        end
    end

    // receiver: start bit checked mid bit, so the stop sample falls mid stop bit
    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_tmr_d = rx_tmr_q;
        rx_sh_d = rx_sh_q;
        rx_cnt_d = rx_cnt_q;
        rx_nxt = {rxd, rx_sh_q[9:1]};
        rx_done = 1'b0;
        rx_byte = (mode == MODE_UART8) ? rx_nxt[8:1] : rx_nxt[7:0];
        rx_ninth = (mode == MODE_UART8) ? rx_nxt[9] : rx_nxt[8];
        rx_stop = rx_nxt[9];
        rx_hit = addr_hit(rx_byte, addr_q[7:0], addr_q[15:8]);
        if (mode == MODE_SHIFT)
            rx_byte = rx_nxt[9:2];
        if (!ctrl_q[CTRL_RX_ENABLE])
            rx_st_d = RX_IDLE;
        else if (rx_st_q == RX_IDLE)
        begin
            rx_cnt_d = 4'h0;
            // mode 00 reception starts only with the flag clear and the line free
            if (mode == MODE_SHIFT)
            begin
                if (!status_q[STAT_RX_DONE] && tx_st_q == TX_IDLE && !tx_start)
                begin
                    rx_st_d = RX_RUN;
                    rx_tmr_d = period - 16'h0001;
                end
            end
            else if (!rxd)
            begin
                rx_st_d = RX_RUN;
                rx_tmr_d = {1'b0, period[15:1]};
            end
        end
        else if (rx_tmr_q != 16'h0000)
            rx_tmr_d = rx_tmr_q - 16'h0001;
        else
        begin
            rx_tmr_d = period - 16'h0001;
            rx_cnt_d = rx_cnt_q + 4'h1;
            if (mode != MODE_SHIFT && rx_cnt_q == 4'h0)
            begin
                if (rxd)
                    rx_st_d = RX_IDLE;
            end
            else
            begin
                rx_sh_d = rx_nxt;
                if ((mode == MODE_SHIFT && rx_cnt_q == LEN_SHIFT) || (mode == MODE_UART8 && rx_cnt_q == LEN_UART8)
                    || (mode[1] && rx_cnt_q == LEN_UART9))
                begin
                    rx_st_d = RX_IDLE;
                    rx_done = 1'b1;
                end
            end
        end
        // qualification; filter enable has no effect in mode 00
        if (!ctrl_q[CTRL_FILTER] || mode == MODE_SHIFT)
            rx_fire = rx_done;
        else if (mode == MODE_UART8)
            rx_fire = rx_done && rx_stop && rx_hit;
        else
            rx_fire = rx_done && rx_ninth && rx_hit;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_st_q <= RX_IDLE;
            rx_tmr_q <= 16'h0000;
            rx_sh_q <= 10'h000;
            rx_cnt_q <= 4'h0;
        end
        else
        begin
            rx_st_q <= rx_st_d;
            rx_tmr_q <= rx_tmr_d;
            rx_sh_q <= rx_sh_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign txd = txd_q;
    assign shift_data_out = sdo_q;
    assign shift_data_oe = soe_q;
    assign irq = irq_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_shift_period: assert property (tx_start && mode == MODE_SHIFT |=> tx_tmr_q == 16'h000b)
        else $error("shift mode bit time is not twelve cycles");
    a_uart8_rate: assert property (
        tx_start && mode == MODE_UART8 && baud_q > 16'h0001 |=> tx_tmr_q == $past(baud_q) - 16'h0001)
        else $error("8-bit mode does not use programmed bit time");
    a_fixed_rate: assert property (
        tx_start && mode == MODE_FIXED9 |=> tx_tmr_q == (ctrl_q[CTRL_FAST] ? 16'h001f : 16'h003f))
        else $error("fixed 9-bit rate wrong");
    a_var9_len: assert property (tx_start && mode == MODE_VAR9 |=> tx_cnt_q == 4'ha && tx_st_q == TX_RUN)
        else $error("9-bit frame length wrong");
    a_nine_filter: assert property (rx_fire && mode[1] && ctrl_q[CTRL_FILTER] |-> rx_ninth && rx_hit)
        else $error("9-bit filter passed a data frame");
    a_eight_filter: assert property (
        rx_fire && mode == MODE_UART8 && ctrl_q[CTRL_FILTER] |-> rx_stop && rx_hit)
        else $error("8-bit filter passed a bad frame");
    a_rx_gated: assert property (!ctrl_q[CTRL_RX_ENABLE] |=> rx_st_q == RX_IDLE ##1 !rx_fire)
        else $error("receiver ran while disabled");
    a_ninth_sent: assert property (tx_start && mode[1] |=> tx_sh_q[8] == $past(ctrl_q[CTRL_TX_NINTH]))
        else $error("ninth bit not loaded");
    a_stop_kept: assert property (
        rx_fire && mode == MODE_UART8 && !ctrl_q[CTRL_FILTER] |=> ctrl_q[CTRL_RX_NINTH] == $past(rxd))
        else $error("stop bit not stored");
    a_flag_set: assert property (rx_fire |=> status_q[STAT_RX_DONE] && rxbuf_q == $past(rx_byte))
        else $error("receive flag not set");
    a_irq_follow: assert property ((status_q & mask_q) != 2'h0 |-> irq_q)
        else $error("interrupt not raised");
    c_uart8_rx: cover property (rx_fire && mode == MODE_UART8);
    c_fixed9_tx: cover property (tx_done && mode == MODE_FIXED9);
    c_shift_rx: cover property (rx_fire && mode == MODE_SHIFT);
endmodule

/* test/smaf_remote_node.sv */
`timescale 1ns/1ps
module smaf_remote_node (
    // line
    input wire logic clock,
    input wire logic txd,
    output logic rxd,
    // frame shape
    input wire logic [15:0] bit_time,
    input wire logic nine_bits,
    // last frame heard
    output logic [8:0] heard,
    output logic heard_stop
);
    initial rxd = 1'b1;
    // stop may be sent low on purpose to fake a broken frame
    task automatic send_frame(input logic [7:0] data, input logic ninth, input logic stop);
        logic [10:0] bits;
        bits = {stop, ninth, data, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            if (i != 9 || nine_bits)
            begin
                rxd <= bits[i];
                repeat (bit_time) @(posedge clock);
            end
        end
        rxd <= 1'b1;
        repeat (bit_time) @(posedge clock);
    endtask
    always @(negedge txd)
    begin
        logic [9:0] f;
        int n;
        n = nine_bits ? 10 : 9;
        f = '0;
        repeat (bit_time / 2) @(posedge clock);
        for (int i = 0; i < n; i++)
        begin
            repeat (bit_time) @(posedge clock);
            f[i] = txd;
        end
        heard = {nine_bits & f[8], f[7:0]};
        heard_stop = f[n - 1];
    end
endmodule

/* test/tb_smaf_top.sv */
`timescale 1ns/1ps
module tb_smaf_top;
    import smaf_pkg::*;
    logic clock = 1'b0, rst = 1'b1, rxd, txd, irq, nine_bits = 1'b0, sdo, soe, heard_stop;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] bit_time = 16'h0010;
    logic [8:0] heard;
    int miscompares = 0, num_checks = 0, cycles = 0, n, m;
    always #2.5 clock = ~clock;
    smaf_top i_smaf_top (.clock(clock), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rxd(rxd),
        .txd(txd), .shift_data_out(sdo), .shift_data_oe(soe), .irq(irq));
    smaf_remote_node i_smaf_remote_node (.clock(clock), .txd(txd), .rxd(rxd), .bit_time(bit_time),
        .nine_bits(nine_bits), .heard(heard), .heard_stop(heard_stop));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        axi_read(a);
        check(what, rdat, exp);
        check("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] md, input logic f, r, t, fast);
        return {24'h0, md, f, r, t, 1'b0, fast, 1'b0};
    endfunction
    // one received frame, then the flag is cleared so the next case starts clean
    task automatic rx_case(input logic [7:0] b, input logic ninth, stop, flag);
        i_smaf_remote_node.send_frame(b, ninth, stop);
        rd(REG_STATUS, {31'h0, flag}, "rx flag");
        if (flag) rd(REG_RXDATA, {24'h0, b}, "rx byte");
        axi_write(REG_STATUS, 32'h1, RESP_OKAY);
    endtask
    task automatic tx_case(input logic [7:0] b, input logic [8:0] exp);
        axi_write(REG_TXDATA, {24'h0, b}, RESP_OKAY);
        rdat = '0;
        while (rdat[STAT_TX_DONE] !== 1'b1) axi_read(REG_STATUS);
        check("frame heard", {23'h0, heard}, {23'h0, exp});
        check("stop heard", {31'h0, heard_stop}, 32'h1);
        axi_write(REG_STATUS, 32'h2, RESP_OKAY);
    endtask
    task automatic final_report();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // generous: the longest frames here take a few hundred cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(REG_CTRL, {24'h0, CTRL_RST}, "ctrl reset");
        rd(REG_BAUD, {16'h0, BAUD_RST}, "baud reset");
        rd(REG_ADDR, {16'h0, ADDR_RST}, "addr reset");
        rd(REG_STATUS, 32'h0, "status reset");
        rd(REG_MASK, 32'h0, "mask reset");
        axi_write(8'h1c, 32'hffff_ffff, RESP_SLVERR);
        axi_read(8'h1c);
        check("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        check("unmapped rdata", rdat, 32'h0);
        axi_write(REG_BAUD, 32'h10, RESP_OKAY);
        axi_write(REG_CTRL, ctl(MODE_UART8, 1'b0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
        i_smaf_remote_node.send_frame(8'ha5, 1'b0, 1'b1);
        rd(REG_STATUS, 32'h1, "rx flag");
        rd(REG_RXDATA, 32'ha5, "rx byte");
        rd(REG_CTRL, ctl(MODE_UART8, 1'b0, 1'b1, 1'b0, 1'b0) | 32'h4, "stop as ninth");
        check("irq masked", {31'h0, irq}, 32'h0);
        axi_write(REG_MASK, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clock);
        check("irq raised", {31'h0, irq}, 32'h1);
        axi_write(REG_STATUS, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clock);
        check("irq cleared", {31'h0, irq}, 32'h0);
        axi_write(REG_CTRL, ctl(MODE_UART8, 1'b0, 1'b0, 1'b0, 1'b0), RESP_OKAY);
        rx_case(8'h33, 1'b0, 1'b1, 1'b0);
        axi_write(REG_ADDR, 32'hfdc0, RESP_OKAY);
        axi_write(REG_CTRL, ctl(MODE_UART8, 1'b1, 1'b1, 1'b0, 1'b0), RESP_OKAY);
        rx_case(8'hc2, 1'b0, 1'b0, 1'b0);
        rx_case(8'hc2, 1'b0, 1'b1, 1'b1);
        tx_case(8'h5a, 9'h05a);
        nine_bits <= 1'b1;
        axi_write(REG_CTRL, ctl(MODE_VAR9, 1'b1, 1'b1, 1'b0, 1'b0), RESP_OKAY);
        rx_case(8'hc0, 1'b0, 1'b1, 1'b0);
        rx_case(8'hc2, 1'b1, 1'b1, 1'b1);
        rx_case(8'hc1, 1'b1, 1'b1, 1'b0);
        rx_case(8'hfd, 1'b1, 1'b1, 1'b1);
        axi_write(REG_CTRL, ctl(MODE_VAR9, 1'b0, 1'b0, 1'b1, 1'b0), RESP_OKAY);
        tx_case(8'h3c, 9'h13c);
        bit_time <= 16'h0020;
        axi_write(REG_CTRL, ctl(MODE_FIXED9, 1'b0, 1'b0, 1'b0, 1'b1), RESP_OKAY);
        tx_case(8'h96, 9'h096);
        // line held low: a filtering receiver would reject this byte, mode 00 must not
        fork
            i_smaf_remote_node.send_frame(8'h00, 1'b0, 1'b0);
            axi_write(REG_CTRL, ctl(MODE_SHIFT, 1'b1, 1'b1, 1'b0, 1'b0), RESP_OKAY);
        join
        rd(REG_STATUS, 32'h1, "shift rx flag");
        rd(REG_RXDATA, 32'h0, "shift rx byte");
        axi_write(REG_CTRL, ctl(MODE_SHIFT, 1'b1, 1'b0, 1'b0, 1'b0), RESP_OKAY);
        axi_write(REG_TXDATA, 32'h02, RESP_OKAY);
        @(negedge txd);
        n = 0;
        m = 0;
        @(posedge clock);
        while (txd === 1'b0)
        begin
            n++;
            @(posedge clock);
        end
        check("shift data", {31'h0, sdo}, 32'h1);
        check("shift drive", {31'h0, soe}, 32'h1);
        while (txd === 1'b1 && m < 20)
        begin
            m++;
            @(posedge clock);
        end
        check("shift clock low", n, 6);
        check("shift clock high", m, 6);
        rdat = '0;
        while (rdat[STAT_TX_DONE] !== 1'b1) axi_read(REG_STATUS);
        check("shift drive off", {31'h0, soe}, 32'h0);
        final_report();
    end
endmodule
